// ===== cpd_config_regs.sv
// Channel power and filter configuration register bank.
//
// Summary of operation
// - Gang bit makes all lanes use lane 1 volume.
// - Two-bit field selects zero to three filter sections.
// - Ramp bypass bit disables soft gain stepping.
// - Four lane enables; lanes 1 and 2 on after reset.
// - Slot enable clear holds slot in high impedance.
// - Bias bit powers the microphone bias supply.
// - PDM bit powers enabled lanes, else all off.
// - Loop bit powers the phase-locked loop.
// - Live change off freezes lanes while recording.
// - Live change on lets lanes switch individually.
// - Range code 0 lanes 1-2, code 1 all.
// - Voice detect bit runs the voice detector.
// - Power control register reads zero after reset.
// - State report is 7 running, 6 idle, 4 sleeping.
// - Every host write updates the transaction checksum.
`timescale 1ns/1ps
module cpd_config_regs
    import cpd_pkg::*;
(
    // Clock and reset.
    input  wire  logic                        clk,
    input  wire  logic                        sys_rst,
    // Register port.
    input  wire  logic                        reg_wr_en,
    input  wire  logic                        reg_rd_en,
    input  wire  logic [cpd_pkg::ADDR_W-1:0]  reg_addr,
    input  wire  logic [cpd_pkg::DATA_W-1:0]  reg_wdata,
    output logic       [cpd_pkg::DATA_W-1:0]  reg_rdata,
    output logic                              reg_rd_valid,
    // Device mode.
    input  wire  logic                        device_active,
    // Volume settings of each lane.
    input  wire  logic [cpd_pkg::DATA_W-1:0]  lane1_volume,
    input  wire  logic [cpd_pkg::DATA_W-1:0]  lane2_volume,
    input  wire  logic [cpd_pkg::DATA_W-1:0]  lane3_volume,
    input  wire  logic [cpd_pkg::DATA_W-1:0]  lane4_volume,
    // Volume applied by each lane.
    output logic       [cpd_pkg::DATA_W-1:0]  applied1_volume,
    output logic       [cpd_pkg::DATA_W-1:0]  applied2_volume,
    output logic       [cpd_pkg::DATA_W-1:0]  applied3_volume,
    output logic       [cpd_pkg::DATA_W-1:0]  applied4_volume,
    // Filter controls.
    output logic       [1:0]                  filter_sections,
    output logic                              filter_sections_on,
    output logic                              soft_step_on,
    // Lane and slot controls, bit 3 is lane 1.
    output logic       [cpd_pkg::LANES-1:0]   lane_power_on,
    output logic       [cpd_pkg::LANES-1:0]   slot_drive_en,
    // Power controls.
    output logic                              bias_supply_on,
    output logic                              synth_loop_on,
    output logic                              voice_detect_on,
    // Status.
    output logic       [2:0]                  operating_state_report,
    output logic       [cpd_pkg::DATA_W-1:0]  transaction_checksum
);
    import cpd_pkg::*;

    logic [7:0]       filter_q;
    logic [7:0]       filter_d;
    logic [3:0]       lane_en_q;
    logic [3:0]       lane_en_d;
    logic [3:0]       slot_en_q;
    logic [3:0]       slot_en_d;
    logic [7:0]       power_q;
    logic [7:0]       power_d;
    logic [7:0]       chk_q;
    logic [7:0]       chk_d;
    logic [3:0]       lane_pwr_q;
    logic [3:0]       lane_pwr_d;
    cpd_op_state_type state_q;
    cpd_op_state_type state_d;
    logic [7:0]       rdata_q;
    logic [7:0]       rdata_d;
    logic             rd_valid_q;
    logic             rd_valid_d;

    logic             pdm_lanes_on;
    logic             live_lane_power_change;
    logic [1:0]       live_lane_range;
    logic [3:0]       live_mask;
    logic [3:0]       lane_target;

    // Checksum accumulates address and data of each write, modulo 256; a write to the checksum register loads the data instead.
    function automatic logic [7:0] chk_step(input logic [7:0] sum,
                                            input logic [7:0] addr,
                                            input logic [7:0] data);
        chk_step = 8'(sum + addr + data);
    endfunction

    assign pdm_lanes_on           = power_q[PDM_LANES_BIT];
    assign live_lane_power_change = power_q[LIVE_CHANGE_BIT];
    assign live_lane_range        = power_q[LIVE_RANGE_MSB:LIVE_RANGE_LSB];
    assign lane_target            = pdm_lanes_on ? lane_en_q : 4'h0;

    // Reserved range codes fall back to the two-lane range.
    assign live_mask = (live_lane_range == LIVE_RANGE_FOUR) ? LIVE_MASK_FOUR
                                                            : LIVE_MASK_TWO;

    // Register writes.
    always_comb begin
        filter_d = filter_q;
        lane_en_d = lane_en_q;
        slot_en_d = slot_en_q;
        power_d = power_q;
        chk_d = chk_q;
        if (reg_wr_en) begin
            chk_d = chk_step(chk_q, reg_addr, reg_wdata);
            if (reg_addr == FILTER_VOLUME_CONFIG_ADDR) begin
                filter_d = reg_wdata;
            end else if (reg_addr == INPUT_LANE_ENABLES_ADDR) begin
                lane_en_d = reg_wdata[LANE_FIELD_MSB:LANE_FIELD_LSB];
            end else if (reg_addr == OUTPUT_SLOT_ENABLES_ADDR) begin
                slot_en_d = reg_wdata[LANE_FIELD_MSB:LANE_FIELD_LSB];
            end else if (reg_addr == POWER_UP_CONTROL_ADDR) begin
                power_d = reg_wdata;
            end else if (reg_addr == CHECKSUM_ADDR) begin
                chk_d = reg_wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            filter_q  <= FILTER_VOLUME_CONFIG_RST;
            lane_en_q <= INPUT_LANE_ENABLES_RST[LANE_FIELD_MSB:LANE_FIELD_LSB];
            slot_en_q <= OUTPUT_SLOT_ENABLES_RST[LANE_FIELD_MSB:LANE_FIELD_LSB];
            power_q   <= POWER_UP_CONTROL_RST;
            chk_q     <= CHECKSUM_RST;
        end else begin
            filter_q  <= filter_d;
            lane_en_q <= lane_en_d;
            slot_en_q <= slot_en_d;
            power_q   <= power_d;
            chk_q     <= chk_d;
        end
    end

    // Lane power follows the enables unless recording locks it.
    always_comb begin
        lane_pwr_d = lane_pwr_q;
        if (!pdm_lanes_on) begin
            lane_pwr_d = 4'h0;
        end else if (lane_pwr_q == 4'h0) begin
            lane_pwr_d = lane_target;
        end else if (live_lane_power_change) begin
            lane_pwr_d = (lane_target & live_mask) | (lane_pwr_q & ~live_mask);
        end else begin
            lane_pwr_d = lane_pwr_q;
        end
    end

    // Operating state follows device mode and lane power.
    always_comb begin
        if (!device_active) begin
            state_d = CPD_OP_SLEEP;
        end else if (lane_pwr_q != 4'h0) begin
            state_d = CPD_OP_RUN;
        end else begin
            state_d = CPD_OP_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lane_pwr_q <= 4'h0;
            state_q    <= CPD_OP_SLEEP;
        end else begin
            lane_pwr_q <= lane_pwr_d;
            state_q    <= state_d;
        end
    end

    // Register reads; read-only reserved bits return zero.
    always_comb begin
        rd_valid_d = reg_rd_en;
        rdata_d = rdata_q;
        if (reg_rd_en) begin
            if (reg_addr == FILTER_VOLUME_CONFIG_ADDR) begin
                rdata_d = filter_q;
            end else if (reg_addr == INPUT_LANE_ENABLES_ADDR) begin
                rdata_d = {lane_en_q, 4'h0};
            end else if (reg_addr == OUTPUT_SLOT_ENABLES_ADDR) begin
                rdata_d = {slot_en_q, 4'h0};
            end else if (reg_addr == POWER_UP_CONTROL_ADDR) begin
                rdata_d = power_q;
            end else if (reg_addr == STATE_REPORT_ADDR) begin
                rdata_d = {state_q, 5'h00};
            end else if (reg_addr == CHECKSUM_ADDR) begin
                rdata_d = chk_q;
            end else begin
                rdata_d = READ_ZERO;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q    <= READ_ZERO;
            rd_valid_q <= 1'b0;
        end else begin
            rdata_q    <= rdata_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    cpd_volume_gang u_volume_gang (
        .clk             (clk),
        .sys_rst         (sys_rst),
        .volume_gang     (filter_q[VOLUME_GANG_BIT]),
        .lane1_volume    (lane1_volume),
        .lane2_volume    (lane2_volume),
        .lane3_volume    (lane3_volume),
        .lane4_volume    (lane4_volume),
        .applied1_volume (applied1_volume),
        .applied2_volume (applied2_volume),
        .applied3_volume (applied3_volume),
        .applied4_volume (applied4_volume)
    );

    assign reg_rdata              = rdata_q;
    assign reg_rd_valid           = rd_valid_q;
    assign filter_sections        = filter_q[SECTION_CNT_MSB:SECTION_CNT_LSB];
    assign filter_sections_on     = filter_sections != 2'b00;
    assign soft_step_on           = !filter_q[RAMP_BYPASS_BIT];
    assign lane_power_on          = lane_pwr_q;
    assign slot_drive_en          = slot_en_q;
    assign bias_supply_on         = power_q[BIAS_SUPPLY_BIT];
    assign synth_loop_on          = power_q[SYNTH_LOOP_BIT];
    assign voice_detect_on        = power_q[VOICE_DETECT_BIT];
    assign operating_state_report = state_q;
    assign transaction_checksum   = chk_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_lane_enable_reset: assert property (
        $past(sys_rst) |-> lane_en_q == 4'b1100 && slot_drive_en == 4'h0)
        else $error("Lane or slot enables wrong after reset.");

    a_power_reset_zero: assert property (
        $past(sys_rst) |-> power_q == 8'h00 && !bias_supply_on && !voice_detect_on)
        else $error("Power control not zero after reset.");

    a_section_write: assert property (
        reg_wr_en && reg_addr == FILTER_VOLUME_CONFIG_ADDR
        |=> filter_sections == $past(reg_wdata[6:5]) &&
            soft_step_on == !$past(reg_wdata[4]))
        else $error("Section count or ramp bypass not taken from write.");

    a_power_write: assert property (
        reg_wr_en && reg_addr == POWER_UP_CONTROL_ADDR
        |=> bias_supply_on == $past(reg_wdata[7]) &&
            synth_loop_on == $past(reg_wdata[5]) &&
            voice_detect_on == $past(reg_wdata[0]))
        else $error("Power controls do not follow the written value.");

    a_slot_readback: assert property (
        reg_wr_en && reg_addr == OUTPUT_SLOT_ENABLES_ADDR ##1
        reg_rd_en && reg_addr == OUTPUT_SLOT_ENABLES_ADDR && !reg_wr_en
        |=> reg_rd_valid && reg_rdata[7:4] == $past(reg_wdata[7:4], 2) &&
            reg_rdata[3:0] == 4'h0)
        else $error("Slot enables do not read back as written.");

    a_pdm_off_lanes: assert property (
        !pdm_lanes_on |=> lane_power_on == 4'h0)
        else $error("Lanes powered while PDM power is off.");

    a_locked_lanes: assert property (
        pdm_lanes_on && !live_lane_power_change && lane_pwr_q != 4'h0
        |=> $stable(lane_power_on))
        else $error("Lane power changed while recording and locked.");

    a_range_limit: assert property (
        pdm_lanes_on && live_lane_power_change && live_lane_range == LIVE_RANGE_TWO &&
        lane_pwr_q != 4'h0
        |=> lane_power_on[1:0] == $past(lane_pwr_q[1:0]) &&
            lane_power_on[3:2] == $past(lane_en_q[3:2]))
        else $error("Live switching outside the selected lane range.");

    a_state_code: assert property (
        device_active && lane_pwr_q != 4'h0 ##1 device_active && lane_pwr_q == 4'h0
        |-> operating_state_report == 3'd7 ##1 operating_state_report == 3'd6)
        else $error("Operating state report wrong for lane power.");

    a_checksum_update: assert property (
        reg_wr_en && reg_addr != CHECKSUM_ADDR
        |=> transaction_checksum == 8'($past(chk_q) + $past(reg_addr) + $past(reg_wdata)))
        else $error("Checksum not updated by register write.");

    c_gang_write: cover property (
        reg_wr_en && reg_addr == FILTER_VOLUME_CONFIG_ADDR && reg_wdata[7]);

    c_live_switch: cover property (
        live_lane_power_change && lane_pwr_q != 4'h0 ##1 $changed(lane_power_on));

    c_state_run: cover property (operating_state_report == 3'd7);
endmodule

// ===== cpd_config_regs_tb.sv
// Self-checking testbench for the channel power and filter configuration bank.
`timescale 1ns/1ps
module cpd_config_regs_tb;
    import cpd_pkg::*;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
    } cpd_row_type;

    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        reg_wr_en;
    logic        reg_rd_en;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic        reg_rd_valid;
    logic        device_active = 1'b1;
    logic [7:0]  lane1_volume = 8'h11;
    logic [7:0]  lane2_volume = 8'h22;
    logic [7:0]  lane3_volume = 8'h33;
    logic [7:0]  lane4_volume = 8'h44;
    logic [7:0]  applied1_volume;
    logic [7:0]  applied2_volume;
    logic [7:0]  applied3_volume;
    logic [7:0]  applied4_volume;
    logic [1:0]  filter_sections;
    logic        filter_sections_on;
    logic        soft_step_on;
    logic [3:0]  lane_power_on;
    logic [3:0]  slot_drive_en;
    logic        bias_supply_on;
    logic        synth_loop_on;
    logic        voice_detect_on;
    logic [2:0]  operating_state_report;
    logic [7:0]  transaction_checksum;
    logic [7:0]  cks;
    logic [7:0]  d;
    logic        rd_ok;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    cpd_row_type rows [6];

    always #5 clk = ~clk;

    cpd_host_model host (.clk(clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid));

    cpd_config_regs dut (.clk(clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .device_active(device_active),
        .lane1_volume(lane1_volume), .lane2_volume(lane2_volume),
        .lane3_volume(lane3_volume), .lane4_volume(lane4_volume),
        .applied1_volume(applied1_volume), .applied2_volume(applied2_volume),
        .applied3_volume(applied3_volume), .applied4_volume(applied4_volume),
        .filter_sections(filter_sections), .filter_sections_on(filter_sections_on),
        .soft_step_on(soft_step_on), .lane_power_on(lane_power_on),
        .slot_drive_en(slot_drive_en), .bias_supply_on(bias_supply_on),
        .synth_loop_on(synth_loop_on), .voice_detect_on(voice_detect_on),
        .operating_state_report(operating_state_report),
        .transaction_checksum(transaction_checksum));

    task automatic stop_test();
        $display("Counts: %0d mismatches in %0d comparisons", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        host.write_reg(a, v);
        cks = (a == 8'h7E) ? v : 8'(cks + a + v);
        repeat (2) @(negedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        logic ok;
        host.read_reg(a, v, ok);
        check({7'h00, ok}, 8'h01);
    endtask

    task automatic do_reset();
        sys_rst = 1'b1;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        cks = 8'h00;
    endtask

    initial begin
        rows[0] = '{8'h6C, 8'h20, 8'h20};
        rows[1] = '{8'h6C, 8'hF0, 8'hF0};
        rows[2] = '{8'h73, 8'h30, 8'h30};
        rows[3] = '{8'h74, 8'hF0, 8'hF0};
        rows[4] = '{8'h75, 8'hE5, 8'hE5};
        rows[5] = '{8'h50, 8'h5A, 8'h00};
        do_reset();
        for (int i = 0; i < 6; i++) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, d);
            check(d, rows[i].rdata);
        end
        check(transaction_checksum, cks);
        $display("Test register rows done");
        do_reset();
        rd(8'h6C, d);
        check(d, 8'h40);
        rd(8'h73, d);
        check(d, 8'hC0);
        rd(8'h74, d);
        check(d, 8'h00);
        rd(8'h75, d);
        check(d, 8'h00);
        rd(8'h7E, d);
        check(d, 8'h00);
        check({6'h00, filter_sections}, 8'h02);
        check({7'h00, soft_step_on}, 8'h01);
        check({4'h0, slot_drive_en}, 8'h00);
        check({4'h0, lane_power_on}, 8'h00);
        check({5'h00, operating_state_report}, 8'h06);
        $display("Test reset done");
        for (int g = 0; g < 2; g++) begin
            wr(8'h6C, {g[0], 7'h40});
            check(applied1_volume, 8'h11);
            check(applied2_volume, g ? 8'h11 : 8'h22);
            check(applied3_volume, g ? 8'h11 : 8'h33);
            check(applied4_volume, g ? 8'h11 : 8'h44);
        end
        for (int c = 0; c < 4; c++) begin
            wr(8'h6C, {1'b0, c[1:0], c[0], 4'h0});
            check({6'h00, filter_sections}, 8'(c));
            check({7'h00, filter_sections_on}, {7'h00, c != 0});
            check({7'h00, soft_step_on}, {7'h00, ~c[0]});
        end
        wr(8'h74, 8'h50);
        check({4'h0, slot_drive_en}, 8'h05);
        wr(8'h74, 8'hA0);
        check({4'h0, slot_drive_en}, 8'h0A);
        host.write_read(8'h74, 8'h90, d, rd_ok);
        cks = 8'(cks + 8'h74 + 8'h90);
        check(d, 8'h90);
        check({7'h00, rd_ok}, 8'h01);
        check({4'h0, slot_drive_en}, 8'h09);
        wr(8'h75, 8'hA1);
        check({5'h00, bias_supply_on, synth_loop_on, voice_detect_on}, 8'h07);
        check({4'h0, lane_power_on}, 8'h00);
        $display("Test field outputs done");
        wr(8'h75, 8'h40);
        check({4'h0, lane_power_on}, 8'h0C);
        check({5'h00, operating_state_report}, 8'h07);
        check({5'h00, bias_supply_on, synth_loop_on, voice_detect_on}, 8'h00);
        wr(8'h73, 8'hF0);
        check({4'h0, lane_power_on}, 8'h0C);
        wr(8'h75, 8'h50);
        check({4'h0, lane_power_on}, 8'h0C);
        wr(8'h73, 8'h70);
        check({4'h0, lane_power_on}, 8'h04);
        wr(8'h75, 8'h54);
        check({4'h0, lane_power_on}, 8'h07);
        device_active = 1'b0;
        repeat (2) @(negedge clk);
        check({5'h00, operating_state_report}, 8'h04);
        device_active = 1'b1;
        wr(8'h75, 8'h00);
        check({4'h0, lane_power_on}, 8'h00);
        check({5'h00, operating_state_report}, 8'h06);
        wr(8'h77, 8'hFF);
        rd(8'h77, d);
        check(d, 8'hC0);
        $display("Test lane power done");
        check(transaction_checksum, cks);
        rd(8'h7E, d);
        check(d, cks);
        wr(8'h7E, 8'h5A);
        check(transaction_checksum, 8'h5A);
        wr(8'h74, 8'h20);
        check(transaction_checksum, 8'hEE);
        $display("Test checksum done");
        stop_test();
    end
endmodule

// ===== cpd_host_model.sv
// Register host model that drives the configuration bank's write and read strobes.
`timescale 1ns/1ps
module cpd_host_model
    import cpd_pkg::*;
(
    // Clock.
    input  wire  logic                       clk,
    // Register port.
    output logic                             reg_wr_en,
    output logic                             reg_rd_en,
    output logic       [cpd_pkg::ADDR_W-1:0] reg_addr,
    output logic       [cpd_pkg::DATA_W-1:0] reg_wdata,
    input  wire  logic [cpd_pkg::DATA_W-1:0] reg_rdata,
    input  wire  logic                       reg_rd_valid
);
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    // Reserved fields always carry their reset value and the range never takes codes 2 or 3.
    function automatic logic [7:0] legal_data(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] d;
        d = data;
        if (addr == 8'h6C || addr == 8'h73 || addr == 8'h74) begin
            d[3:0] = 4'h0;
        end
        if (addr == 8'h75) begin
            d[1] = 1'b0;
            d[3] = 1'b0;
        end
        return d;
    endfunction

    // A released address or data bus shows the inverse of its last value.
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk);
        reg_addr  = addr;
        reg_wdata = legal_data(addr, data);
        reg_wr_en = 1'b1;
        @(posedge clk);
        @(negedge clk);
        reg_wr_en = 1'b0;
        reg_addr  = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic valid);
        @(negedge clk);
        reg_addr  = addr;
        reg_rd_en = 1'b1;
        @(posedge clk);
        @(negedge clk);
        data      = reg_rdata;
        valid     = reg_rd_valid;
        reg_rd_en = 1'b0;
        reg_addr  = ~reg_addr;
    endtask

    // Writes a register and reads it back on the very next edge.
    task automatic write_read(input logic [7:0] addr, input logic [7:0] wdata,
                              output logic [7:0] data, output logic valid);
        @(negedge clk);
        reg_addr  = addr;
        reg_wdata = legal_data(addr, wdata);
        reg_wr_en = 1'b1;
        @(negedge clk);
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b1;
        @(negedge clk);
        data      = reg_rdata;
        valid     = reg_rd_valid;
        reg_rd_en = 1'b0;
        reg_addr  = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask
endmodule

// ===== cpd_pkg.sv
// Constants and types shared by the channel power and filter configuration bank.
package cpd_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned LANES  = 4;

    // Register offsets.
    localparam logic [7:0] FILTER_VOLUME_CONFIG_ADDR = 8'h6C;
    localparam logic [7:0] INPUT_LANE_ENABLES_ADDR   = 8'h73;
    localparam logic [7:0] OUTPUT_SLOT_ENABLES_ADDR  = 8'h74;
    localparam logic [7:0] POWER_UP_CONTROL_ADDR     = 8'h75;
    localparam logic [7:0] STATE_REPORT_ADDR         = 8'h77;
    localparam logic [7:0] CHECKSUM_ADDR             = 8'h7E;

    // Reset values.
    localparam logic [7:0] FILTER_VOLUME_CONFIG_RST = 8'h40;
    localparam logic [7:0] INPUT_LANE_ENABLES_RST   = 8'hC0;
    localparam logic [7:0] OUTPUT_SLOT_ENABLES_RST  = 8'h00;
    localparam logic [7:0] POWER_UP_CONTROL_RST     = 8'h00;
    localparam logic [7:0] CHECKSUM_RST             = 8'h00;

    // Field positions in the filter and volume configuration register.
    localparam int unsigned VOLUME_GANG_BIT  = 7;
    localparam int unsigned SECTION_CNT_MSB  = 6;
    localparam int unsigned SECTION_CNT_LSB  = 5;
    localparam int unsigned RAMP_BYPASS_BIT  = 4;

    // Field positions in the lane and slot enable registers; bit 7 is lane 1.
    localparam int unsigned LANE_FIELD_MSB   = 7;
    localparam int unsigned LANE_FIELD_LSB   = 4;

    // Field positions in the power control register.
    localparam int unsigned BIAS_SUPPLY_BIT  = 7;
    localparam int unsigned PDM_LANES_BIT    = 6;
    localparam int unsigned SYNTH_LOOP_BIT   = 5;
    localparam int unsigned LIVE_CHANGE_BIT  = 4;
    localparam int unsigned LIVE_RANGE_MSB   = 3;
    localparam int unsigned LIVE_RANGE_LSB   = 2;
    localparam int unsigned VOICE_DETECT_BIT = 0;

    // Field position of the state report.
    localparam int unsigned STATE_FIELD_MSB  = 7;
    localparam int unsigned STATE_FIELD_LSB  = 5;

    // Lanes reachable by live power switching, bit 3 being lane 1.
    localparam logic [1:0] LIVE_RANGE_TWO   = 2'b00;
    localparam logic [1:0] LIVE_RANGE_FOUR  = 2'b01;
    localparam logic [3:0] LIVE_MASK_TWO    = 4'b1100;
    localparam logic [3:0] LIVE_MASK_FOUR   = 4'b1111;

    localparam logic [7:0] READ_ZERO = 8'h00;

    typedef enum logic [2:0] {
        CPD_OP_SLEEP = 3'b100,
        CPD_OP_IDLE  = 3'b110,
        CPD_OP_RUN   = 3'b111
    } cpd_op_state_type;
endpackage

// ===== cpd_volume_gang.sv
// Per-lane volume selection with optional ganging to lane 1.
`timescale 1ns/1ps
module cpd_volume_gang
    import cpd_pkg::*;
(
    // Clock and reset.
    input  wire  logic                      clk,
    input  wire  logic                      sys_rst,
    // Control.
    input  wire  logic                      volume_gang,
    // Volume settings of each lane.
    input  wire  logic [cpd_pkg::DATA_W-1:0] lane1_volume,
    input  wire  logic [cpd_pkg::DATA_W-1:0] lane2_volume,
    input  wire  logic [cpd_pkg::DATA_W-1:0] lane3_volume,
    input  wire  logic [cpd_pkg::DATA_W-1:0] lane4_volume,
    // Volume applied by each lane.
    output logic       [cpd_pkg::DATA_W-1:0] applied1_volume,
    output logic       [cpd_pkg::DATA_W-1:0] applied2_volume,
    output logic       [cpd_pkg::DATA_W-1:0] applied3_volume,
    output logic       [cpd_pkg::DATA_W-1:0] applied4_volume
);
    import cpd_pkg::*;

    logic [DATA_W-1:0] vol_d [LANES];
    logic [DATA_W-1:0] vol_q [LANES];

    // Ganged lanes follow lane 1 whether or not lane 1 is running.
    always_comb begin
        vol_d[0] = lane1_volume;
        vol_d[1] = volume_gang ? lane1_volume : lane2_volume;
        vol_d[2] = volume_gang ? lane1_volume : lane3_volume;
        vol_d[3] = volume_gang ? lane1_volume : lane4_volume;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < LANES; i++) begin
                vol_q[i] <= '0;
            end
        end else begin
            vol_q <= vol_d;
        end
    end

    assign applied1_volume = vol_q[0];
    assign applied2_volume = vol_q[1];
    assign applied3_volume = vol_q[2];
    assign applied4_volume = vol_q[3];

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_gang_lane_volume: assert property (
        volume_gang |=> applied4_volume == $past(lane1_volume) &&
                        applied2_volume == $past(lane1_volume))
        else $error("Ganged lane does not apply lane 1 volume.");

    a_own_lane_volume: assert property (
        !volume_gang |=> applied3_volume == $past(lane3_volume))
        else $error("Ungated lane does not apply its own volume.");
endmodule
